//--- verilog/pwn_pkg.sv
// pwn_pkg: register map, field layout, reset values and timing constants
// for the port-write notification register bank.
// assumes a 100 MHz core clock and a 32-bit AHB-Lite register port.
`default_nettype none
package pwn_pkg;

  // ==========================================================================
  // register byte addresses
  localparam logic [31:0] RESET_REQUEST_NOTIFY_ENABLE_ADDR = 32'h0001_0970;
  localparam logic [31:0] NOTIFY_STATUS_ADDR = 32'h0001_0974;
  localparam logic [31:0] NOTIFY_BLOCK_HEADER_ADDR = 32'h0001_0a00;
  localparam logic [31:0] NOTIFY_CONTROL_ADDR = 32'h0001_0a04;

  // ==========================================================================
  // field positions (bit 0 is the least significant bit of the bus word)
  localparam int NOTIFY_ENABLE_BIT = 0;
  localparam int NEXT_BLOCK_POINTER_LSB = 16;
  localparam int BLOCK_REVISION_LSB = 12;
  localparam int BLOCK_KIND_LSB = 0;
  localparam int REPEAT_PERIOD_LSB = 28;
  localparam int CAPTURE_POLICY_BIT = 24;
  localparam int STATUS_SOURCE_BIT = 0;
  localparam int STATUS_REPEAT_BIT = 1;

  // ==========================================================================
  // header contents and reset values
  localparam logic [15:0] NEXT_BLOCK_POINTER = 16'h010d;
  localparam logic [3:0] BLOCK_REVISION_RESET = 4'h0; // arbitrary neutral revision code
  localparam logic [11:0] BLOCK_KIND_RESET = 12'h000; // arbitrary neutral kind code
  localparam logic [3:0] REPEAT_PERIOD_RESET = 4'h0;
  localparam logic CAPTURE_POLICY_RESET = 1'b0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // repeat-period codes: zero for once, the others one-hot
  localparam logic [3:0] REPEAT_ONCE = 4'h0;
  localparam logic [3:0] REPEAT_CODE_1 = 4'h1;
  localparam logic [3:0] REPEAT_CODE_2 = 4'h2;
  localparam logic [3:0] REPEAT_CODE_4 = 4'h4;
  localparam logic [3:0] REPEAT_CODE_8 = 4'h8;

  // ==========================================================================
  // timing: periods in microseconds, counted in service ticks of 1 us
  localparam int CLK_PERIOD_NS = 10;
  localparam int SERVICE_TICK_NS = 1000;
  localparam int SERVICE_TICK_CYCLES = SERVICE_TICK_NS / CLK_PERIOD_NS;
  localparam int REPEAT_1_US = 103;
  localparam int REPEAT_2_US = 205;
  localparam int REPEAT_4_US = 410;
  localparam int REPEAT_8_US = 820;
  localparam int PERIOD_WIDTH = 10;

  // AHB transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;

  typedef enum logic {REPEAT_IDLE, REPEAT_RUNNING} pwn_repeat_state_type;

endpackage
`default_nettype wire

//--- verilog/pwn_notify_regs.sv
// pwn_notify_regs: port-write notification register bank with reset-request
// notification, error-report repeat timer and capture-policy control.
// assumes AHB-Lite single-word transfers, synchronous event inputs and a
// port-write transmitter that accepts one-cycle send pulses.
// limitations: HSIZE is not decoded, so a narrow write acts on the whole
// word; HRESP is always OKAY, unmapped words included. every repeat period
// is counted in service ticks of TICK_CYCLES clocks, so a smaller value
// shortens all periods in proportion, which keeps simulation runs short
// without changing the ratios between the four codes.
//
// Functional notes
// - reset request plus enable sends port-write
// - next-block pointer reads back fixed value
// - header holds read-only revision and kind
// - period zero sends error port-write once
// - one-hot codes pick 103/205/410/820 us
// - resend pending error port-write each expiry
// - error-detect write stops the repeat timer
// - period from service tick, within ten percent
// - next error report uses newly programmed period
// - capture bit selects continuous or reliable
// - flag reset-request source, software clears it
`timescale 1ns/1ps
`default_nettype none
module pwn_notify_regs
  import pwn_pkg::*;
#(
  parameter int TICK_CYCLES = SERVICE_TICK_CYCLES,
  parameter logic [3:0] BLOCK_REVISION = BLOCK_REVISION_RESET,
  parameter logic [11:0] BLOCK_KIND = BLOCK_KIND_RESET
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  // ahb-lite slave port
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // events from the port and the device
  input wire logic RESET_REQUEST,
  input wire logic ERROR_EVENT,
  input wire logic ERROR_DETECT_WRITE,
  input wire logic GLOBAL_NOTIFY_ENABLE,
  // requests to the port-write transmitter and capture logic
  output logic RESET_PW_SEND,
  output logic ERROR_PW_SEND,
  output logic CAPTURE_POLICY,
  output logic REPEAT_ACTIVE
);

  // ==========================================================================
  // elaboration checks
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("TICK_CYCLES must lie between 1 and 65535");
  end
  // the longest one-hot period must fit the tick counter
  if (REPEAT_8_US >= (1 << PERIOD_WIDTH)) begin : g_bad_width
    $error("PERIOD_WIDTH is too narrow for the longest repeat period");
  end

  // ==========================================================================
  // functions

  // period in service ticks for a one-hot code; zero for once or reserved
  // a reserved code therefore behaves as send-once
  function automatic logic [PERIOD_WIDTH-1:0] period_ticks(input logic [3:0] code);
    logic [PERIOD_WIDTH-1:0] ticks;
    ticks = '0;
    unique case (code)
      REPEAT_CODE_1: ticks = PERIOD_WIDTH'(REPEAT_1_US);
      REPEAT_CODE_2: ticks = PERIOD_WIDTH'(REPEAT_2_US);
      REPEAT_CODE_4: ticks = PERIOD_WIDTH'(REPEAT_4_US);
      REPEAT_CODE_8: ticks = PERIOD_WIDTH'(REPEAT_8_US);
      default: ticks = '0;
    endcase
    return ticks;
  endfunction

  // word address of a byte address; the two low bits never select a register
  function automatic logic [31:0] word_address(input logic [31:0] addr);
    return {addr[31:2], 2'b00};
  endfunction

  // read value of one register word; unmapped words read zero
  // fields sit with bit 0 as the least significant bit of the bus word
  function automatic logic [31:0] read_word(
    input logic [31:0] addr,
    input logic notify_en,
    input logic [3:0] period,
    input logic policy,
    input logic source,
    input logic repeating
  );
    logic [31:0] word;
    word = READ_ZERO;
    if (addr == RESET_REQUEST_NOTIFY_ENABLE_ADDR) begin
      word[NOTIFY_ENABLE_BIT] = notify_en;
    end else if (addr == NOTIFY_STATUS_ADDR) begin
      word[STATUS_SOURCE_BIT] = source;
      word[STATUS_REPEAT_BIT] = repeating;
    end else if (addr == NOTIFY_BLOCK_HEADER_ADDR) begin
      word[NEXT_BLOCK_POINTER_LSB +: 16] = NEXT_BLOCK_POINTER;
      word[BLOCK_REVISION_LSB +: 4] = BLOCK_REVISION;
      word[BLOCK_KIND_LSB +: 12] = BLOCK_KIND;
    end else if (addr == NOTIFY_CONTROL_ADDR) begin
      word[REPEAT_PERIOD_LSB +: 4] = period;
      word[CAPTURE_POLICY_BIT] = policy;
    end
    return word;
  endfunction

  // ==========================================================================
  // ahb-lite address and data phase
  logic phase_write;
  logic [31:0] phase_addr;
  logic take;
  logic write_now;
  logic hit_enable;
  logic hit_status;
  logic hit_control;

  // a transfer is taken only when the bus is ready; IDLE and BUSY are ignored
  assign take = HSEL && HREADY && HTRANS[HTRANS_ACTIVE_BIT];
  assign write_now = phase_write;

  // register hits of the write now in its data phase
  assign hit_enable = write_now && (phase_addr == RESET_REQUEST_NOTIFY_ENABLE_ADDR);
  assign hit_status = write_now && (phase_addr == NOTIFY_STATUS_ADDR);
  assign hit_control = write_now && (phase_addr == NOTIFY_CONTROL_ADDR);

  // capture the address phase; only whole-word transfers are expected;
  // the write flag drops in any cycle without a taken write, so one
  // data phase never repeats an earlier write
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      phase_write <= 1'b0;
      phase_addr <= '0;
    end else begin
      phase_write <= take && HWRITE;
      if (take) begin
        phase_addr <= word_address(HADDR);
      end
    end
  end

  // the slave never stalls and never errors
  // every register answers within one cycle, so no wait state is needed
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // ==========================================================================
  // register state
  logic notify_enable;
  logic [3:0] repeat_period;
  logic capture_policy;
  logic source_flag;
  logic next_notify_enable;
  logic [3:0] next_repeat_period;
  logic next_capture_policy;
  logic next_source_flag;
  pwn_repeat_state_type repeat_state;

  // next values of software-visible registers, so a read that follows a
  // write back to back already sees the written value
  always_comb begin
    next_notify_enable = notify_enable;
    next_repeat_period = repeat_period;
    next_capture_policy = capture_policy;
    next_source_flag = source_flag;
    if (hit_enable) begin
      next_notify_enable = HWDATA[NOTIFY_ENABLE_BIT];
    end
    // reserved control bits are dropped here, so they always read zero
    if (hit_control) begin
      next_repeat_period = HWDATA[REPEAT_PERIOD_LSB +: 4];
      next_capture_policy = HWDATA[CAPTURE_POLICY_BIT];
    end
    // write one to clear; a new request in the same cycle wins
    if (hit_status && HWDATA[STATUS_SOURCE_BIT]) begin
      next_source_flag = 1'b0;
    end
    if (RESET_REQUEST) begin
      next_source_flag = 1'b1;
    end
  end

  // software registers, all zero after reset
  // the source flag survives a cleared enable; only software clears it
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      notify_enable <= 1'b0;
      repeat_period <= REPEAT_PERIOD_RESET;
      capture_policy <= CAPTURE_POLICY_RESET;
      source_flag <= 1'b0;
    end else begin
      notify_enable <= next_notify_enable;
      repeat_period <= next_repeat_period;
      capture_policy <= next_capture_policy;
      source_flag <= next_source_flag;
    end
  end

  // read data registered at the address phase from the post-write values;
  // using the next values lets a read right behind a write see it at once,
  // at the cost of a longer path from HWDATA to HRDATA
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      HRDATA <= READ_ZERO;
    end else if (take && !HWRITE) begin
      HRDATA <= read_word(word_address(HADDR), next_notify_enable, next_repeat_period,
                          next_capture_policy, next_source_flag,
                          repeat_state == REPEAT_RUNNING);
    end
  end

  // capture policy to the capture logic: 0 continuous, 1 reliable
  assign CAPTURE_POLICY = capture_policy;

  // ==========================================================================
  // reset-request notification
  // the request is queued only while the notify enable stands; the source
  // flag is kept regardless so software can still see the request
  // a request held high sends once for every cycle it stands
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      RESET_PW_SEND <= 1'b0;
    end else begin
      RESET_PW_SEND <= RESET_REQUEST && notify_enable;
    end
  end

  // ==========================================================================
  // service tick: 1 us from the core clock, exact so well inside +/-10 %
  // one prescaler serves every period, so all four codes scale together
  // and a shorter tick in simulation keeps their ratios intact
  logic [15:0] tick_count;
  logic tick;

  assign tick = (tick_count == 16'(TICK_CYCLES - 1));

  // free-running prescaler; a repeat may start anywhere inside a tick, so
  // the first period is short by less than one tick (under 1 %)
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tick_count <= '0;
    end else if (tick) begin
      tick_count <= '0;
    end else begin
      tick_count <= tick_count + 16'h0001;
    end
  end

  // ==========================================================================
  // error-report repeat timer
  logic [PERIOD_WIDTH-1:0] period_reload;
  logic [PERIOD_WIDTH-1:0] period_left;
  logic [PERIOD_WIDTH-1:0] start_ticks;
  logic start;
  logic stop;
  logic expire;
  pwn_repeat_state_type next_repeat_state;

  assign start_ticks = period_ticks(repeat_period);
  assign start = ERROR_EVENT && GLOBAL_NOTIFY_ENABLE;
  // an error detect write is software's answer to the report; clearing
  // the global enable also halts repeats so a reprogramming
  // sequence leaves nothing pending under the old period
  assign stop = ERROR_DETECT_WRITE || !GLOBAL_NOTIFY_ENABLE;
  // expiry is the tick on which one tick is left, so a period of N ticks
  // ends on the Nth tick after the start
  assign expire = (repeat_state == REPEAT_RUNNING) && tick &&
                  (period_left == PERIOD_WIDTH'(1));

  // next state of the repeat timer; a stop outranks a new event and an
  // expiry, and a new event while running restarts with the current code,
  // so a send-once code ends a running repeat
  always_comb begin
    next_repeat_state = repeat_state;
    unique case (repeat_state)
      REPEAT_IDLE: begin
        if (!stop && start && start_ticks != '0) begin
          next_repeat_state = REPEAT_RUNNING;
        end
      end
      REPEAT_RUNNING: begin
        if (stop) begin
          next_repeat_state = REPEAT_IDLE;
        end else if (start && start_ticks == '0) begin
          next_repeat_state = REPEAT_IDLE;
        end
      end
    endcase
  end

  // timer state register
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      repeat_state <= REPEAT_IDLE;
    end else begin
      repeat_state <= next_repeat_state;
    end
  end

  // the period is latched when an error report starts, so a change takes
  // effect with the next error report started; a running repeat keeps the old period
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      period_reload <= '0;
      period_left <= '0;
    end else if (!stop && start) begin
      period_reload <= start_ticks;
      period_left <= start_ticks;
    end else if (!stop && repeat_state == REPEAT_RUNNING && tick) begin
      if (expire) begin
        period_left <= period_reload;
      end else begin
        period_left <= period_left - PERIOD_WIDTH'(1);
      end
    end
  end

  // first send on the event, then one per expiry while repeating
  // an expiry that meets a stop is dropped: software has already answered
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ERROR_PW_SEND <= 1'b0;
    end else begin
      ERROR_PW_SEND <= start || (expire && !stop);
    end
  end

  // timer activity, also shown in the status word
  assign REPEAT_ACTIVE = (repeat_state == REPEAT_RUNNING);

endmodule
`default_nettype wire

//--- sim/pwn_notify_regs_assertions.sv
// pwn_notify_regs_assertions: port-level checks for the notification bank.
// assumes default header parameters and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pwn_notify_regs_chk
  import pwn_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic RESET_REQUEST,
  input wire logic ERROR_EVENT,
  input wire logic ERROR_DETECT_WRITE,
  input wire logic GLOBAL_NOTIFY_ENABLE,
  input wire logic RESET_PW_SEND,
  input wire logic ERROR_PW_SEND,
  input wire logic REPEAT_ACTIVE
);
  // ==========================================================================
  // checks; reset masks them so pulses cut short by reset do not count
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic hdr_rd;
  assign hdr_rd = HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR == NOTIFY_BLOCK_HEADER_ADDR;
  property p_reset_send; !RESET_REQUEST |=> !RESET_PW_SEND; endproperty
  a_reset_send: assert property (p_reset_send) else $error("reset send without request");
  property p_error_send;
    ERROR_EVENT && GLOBAL_NOTIFY_ENABLE && !ERROR_DETECT_WRITE |=> ERROR_PW_SEND;
  endproperty
  a_error_send: assert property (p_error_send) else $error("error event not sent");
  property p_stop; ERROR_DETECT_WRITE |=> !REPEAT_ACTIVE; endproperty
  a_stop: assert property (p_stop) else $error("repeat not stopped");
  property p_global_stop; !GLOBAL_NOTIFY_ENABLE |=> !REPEAT_ACTIVE; endproperty
  a_global_stop: assert property (p_global_stop) else $error("repeat runs while off");
  property p_fell;
    $fell(REPEAT_ACTIVE) |-> $past(ERROR_DETECT_WRITE) || !$past(GLOBAL_NOTIFY_ENABLE);
  endproperty
  a_fell: assert property (p_fell) else $error("repeat ended by itself");
  property p_single; ERROR_PW_SEND && !REPEAT_ACTIVE |-> $past(ERROR_EVENT); endproperty
  a_single: assert property (p_single) else $error("send without event");
  property p_hdr; hdr_rd |=> HRDATA[31:16] == NEXT_BLOCK_POINTER; endproperty
  a_hdr: assert property (p_hdr) else $error("next pointer wrong");
  property p_hdr_id;
    hdr_rd |=> HRDATA[15:0] == {BLOCK_REVISION_RESET, BLOCK_KIND_RESET};
  endproperty
  a_hdr_id: assert property (p_hdr_id) else $error("revision or kind wrong");
endmodule
bind pwn_notify_regs pwn_notify_regs_chk chk_u (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
  .RESET_REQUEST(RESET_REQUEST), .ERROR_EVENT(ERROR_EVENT),
  .ERROR_DETECT_WRITE(ERROR_DETECT_WRITE), .GLOBAL_NOTIFY_ENABLE(GLOBAL_NOTIFY_ENABLE),
  .RESET_PW_SEND(RESET_PW_SEND), .ERROR_PW_SEND(ERROR_PW_SEND), .REPEAT_ACTIVE(REPEAT_ACTIVE));
`default_nettype wire

//--- sim/pwn_host_model.sv
// pwn_host_model: remote host that receives port-write send pulses.
// assumes one-cycle send pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module pwn_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pw,
  input wire logic error_pw,
  output int reset_count,
  output int error_count,
  output int error_gap
);
  int since;
  // ==========================================================================
  // count arrivals; the gap between error sends exposes the repeat period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_count <= 0;
      error_count <= 0;
      error_gap <= 0;
      since <= 0;
    end else begin
      since <= since + 1;
      if (reset_pw) reset_count <= reset_count + 1;
      if (error_pw) begin
        error_count <= error_count + 1;
        error_gap <= since + 1;
        since <= 0;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/tb_port_write_event_control.sv
// tb_port_write_event_control: self-checking bench for the notification bank.
// assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_port_write_event_control;
  import pwn_pkg::*;
  localparam int TICK = 2;
  logic CORE_CLK = 0, RST = 1, HSEL = 0, HWRITE = 0, RESET_REQUEST = 0;
  logic ERROR_EVENT = 0, ERROR_DETECT_WRITE = 0, GLOBAL_NOTIFY_ENABLE = 1;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
  logic [1:0] HTRANS = 2'h0;
  logic HREADYOUT, HRESP, RESET_PW_SEND, ERROR_PW_SEND, CAPTURE_POLICY, REPEAT_ACTIVE;
  int bad_count = 0, num_checks = 0, cycles = 0, reset_count, error_count, error_gap;
  // ==========================================================================
  // clock, design and far-side host; a short tick keeps periods brief
  always #5 CORE_CLK = ~CORE_CLK;
  pwn_notify_regs #(.TICK_CYCLES(TICK)) dut_u (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .RESET_REQUEST(RESET_REQUEST), .ERROR_EVENT(ERROR_EVENT),
    .ERROR_DETECT_WRITE(ERROR_DETECT_WRITE), .GLOBAL_NOTIFY_ENABLE(GLOBAL_NOTIFY_ENABLE),
    .RESET_PW_SEND(RESET_PW_SEND), .ERROR_PW_SEND(ERROR_PW_SEND),
    .CAPTURE_POLICY(CAPTURE_POLICY), .REPEAT_ACTIVE(REPEAT_ACTIVE));
  pwn_host_model host_u (.clk(CORE_CLK), .rst(RST), .reset_pw(RESET_PW_SEND),
    .error_pw(ERROR_PW_SEND), .reset_count(reset_count), .error_count(error_count),
    .error_gap(error_gap));
  // ==========================================================================
  // helpers; every task starts and ends just after a rising edge
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= wr;
    @(posedge CORE_CLK);
    while (!HREADYOUT) @(posedge CORE_CLK);
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CORE_CLK);
    while (!HREADYOUT) @(posedge CORE_CLK);
    rd = HRDATA;
  endtask
  task automatic ev(input logic err);
    if (err) ERROR_EVENT <= 1'b1;
    else RESET_REQUEST <= 1'b1;
    @(posedge CORE_CLK);
    ERROR_EVENT <= 1'b0;
    RESET_REQUEST <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  task automatic stop_pulse();
    ERROR_DETECT_WRITE <= 1'b1;
    @(posedge CORE_CLK);
    ERROR_DETECT_WRITE <= 1'b0;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset_values();
    bus(0, RESET_REQUEST_NOTIFY_ENABLE_ADDR, 32'h0);
    chk("enable", 32'h0, rd);
    bus(0, NOTIFY_CONTROL_ADDR, 32'h0);
    chk("control", 32'h0, rd);
    bus(1, NOTIFY_BLOCK_HEADER_ADDR, 32'hffff_ffff);
    chk("write response", 32'h0, HRESP);
    bus(0, NOTIFY_BLOCK_HEADER_ADDR, 32'h0);
    chk("header", {NEXT_BLOCK_POINTER, BLOCK_REVISION_RESET, BLOCK_KIND_RESET}, rd);
    bus(0, 32'h0001_0a0c, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset_values done");
  endtask
  task automatic t_reset_notify();
    int n = reset_count;
    ev(0);
    repeat (2) @(posedge CORE_CLK);
    chk("gated send", n, reset_count);
    bus(0, NOTIFY_STATUS_ADDR, 32'h0);
    chk("source flag", 32'h1, rd & 32'h1);
    bus(1, NOTIFY_STATUS_ADDR, 32'h1);
    bus(0, NOTIFY_STATUS_ADDR, 32'h0);
    chk("source cleared", 32'h0, rd & 32'h1);
    bus(1, RESET_REQUEST_NOTIFY_ENABLE_ADDR, 32'hffff_ffff);
    bus(0, RESET_REQUEST_NOTIFY_ENABLE_ADDR, 32'h0);
    chk("enable", 32'h1, rd);
    ev(0);
    repeat (2) @(posedge CORE_CLK);
    chk("reset send", n + 1, reset_count);
    $display("test reset_notify done");
  endtask
  task automatic t_once();
    int n;
    for (int i = 0; i < 2; i++) begin
      bus(1, NOTIFY_CONTROL_ADDR, 32'(i ? 4'h3 : 4'h0) << REPEAT_PERIOD_LSB);
      n = error_count;
      ev(1);
      repeat (300) @(posedge CORE_CLK);
      chk("single send", n + 1, error_count);
      chk("no repeat", 32'h0, REPEAT_ACTIVE);
    end
    $display("test once done");
  endtask
  task automatic t_periods();
    logic [3:0] codes[4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    int us[4] = '{REPEAT_1_US, REPEAT_2_US, REPEAT_4_US, REPEAT_8_US};
    int n;
    for (int i = 0; i < 4; i++) begin
      GLOBAL_NOTIFY_ENABLE <= 1'b0;
      @(posedge CORE_CLK);
      bus(1, NOTIFY_CONTROL_ADDR, 32'(codes[i]) << REPEAT_PERIOD_LSB);
      stop_pulse();
      GLOBAL_NOTIFY_ENABLE <= 1'b1;
      n = error_count;
      ev(1);
      for (int c = 0; c < 2000 && error_count < n + 2; c++) @(posedge CORE_CLK);
      chk("repeat sent", n + 2, error_count);
      chk("period", 1, error_gap >= (us[i] - 1) * TICK && error_gap <= us[i] * TICK + 1);
      stop_pulse();
      repeat (us[i] * TICK + 4) @(posedge CORE_CLK);
      chk("stopped", n + 2, error_count);
      chk("timer idle", 32'h0, REPEAT_ACTIVE);
    end
    $display("test periods done");
  endtask
  task automatic t_capture();
    bus(1, NOTIFY_CONTROL_ADDR, 32'h1 << CAPTURE_POLICY_BIT);
    @(posedge CORE_CLK);
    chk("reliable", 32'h1, CAPTURE_POLICY);
    bus(0, NOTIFY_CONTROL_ADDR, 32'h0);
    chk("control", 32'h1 << CAPTURE_POLICY_BIT, rd);
    bus(1, NOTIFY_CONTROL_ADDR, 32'h0);
    @(posedge CORE_CLK);
    chk("continuous", 32'h0, CAPTURE_POLICY);
    $display("test capture done");
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // main sequence and hang guard
  initial begin
    repeat (10) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    t_reset_values();
    t_reset_notify();
    t_once();
    t_periods();
    t_capture();
    complete_run();
  end
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      complete_run();
    end
  end
endmodule
`default_nettype wire
